// >>> shared/xport_ctl_defs.svh
// constants for the expansion port output control block
// assumes inclusion by bare name from the design files
`ifndef XPORT_CTL_DEFS_SVH
`define XPORT_CTL_DEFS_SVH

`define CTL_OFFSET 8'h13
`define CTL_RESET 8'h00
`define BIT_RTC_EN 7
`define BIT_HREF_SEL 6
`define FLD_VREF_HI 5
`define FLD_VREF_LO 4
`define BIT_LOCK_SEL 3
`define FLD_FMT_HI 2
`define FLD_FMT_LO 0
`define SAV_EAV_LEAD 8'hFF
`define SAV_EAV_ZERO 8'h00
`define BLANK_LUMA 8'h10
`define BLANK_CHROMA 8'h80
`define STATUS_SRC_LOCK 4'h4
`define OUT_RESET 8'h00

`endif

// >>> shared/xport_ctl_pkg.sv
// types for the expansion port output control block
// assumes xport_ctl_defs.svh on the include path
package xport_ctl_pkg;
    typedef enum logic [2:0] {
        fmt_itu656 = 3'h0,
        fmt_itu656_window = 3'h1,
        fmt_plain422 = 3'h2,
        fmt_rsvd3 = 3'h3,
        fmt_bypass_hi = 3'h4,
        fmt_bypass_lo = 3'h5,
        fmt_rsvd6 = 3'h6,
        fmt_split = 3'h7
    } port_format_type;

    typedef enum logic [1:0] {
        vref_sync = 2'h0,
        vref_field = 2'h1,
        vref_sync_inv = 2'h2,
        vref_field_inv = 2'h3
    } vref_select_type;

    // timing reference code phase inside a 3-word header
    typedef enum logic [1:0] {
        trc_idle,
        trc_lead,
        trc_zero,
        trc_word
    } trc_state_type;
endpackage

// >>> core/xport_sample_mux.sv
// converter bypass multiplexer for the expansion data bus
// assumes the converter samples are 9 bits wide and synchronous to ref_clk
`timescale 1ns/100ps
`include "xport_ctl_defs.svh"

module xport_sample_mux (
    // format and qualifier
    input wire logic [2:0] format_code,
    input wire logic clock_qualifier,
    // converter samples
    input wire logic [8:0] conv_first,
    input wire logic [8:0] conv_second,
    // selected byte
    output logic [7:0] mux_byte
);
    // pick bits 8:1 or 7:0 of a sample
    function automatic logic [7:0] take_bits(input logic [8:0] s, input logic upper);
        take_bits = upper ? s[8:1] : s[7:0];
    endfunction

    // second converter on qualifier high, first on low; split uses first only
    always_comb begin
        unique case (xport_ctl_pkg::port_format_type'(format_code))
            xport_ctl_pkg::fmt_bypass_hi:
                mux_byte = take_bits(clock_qualifier ? conv_second : conv_first, 1'b1);
            xport_ctl_pkg::fmt_bypass_lo:
                mux_byte = take_bits(clock_qualifier ? conv_second : conv_first, 1'b0);
            xport_ctl_pkg::fmt_split:
                mux_byte = take_bits(conv_first, clock_qualifier);
            default:
                mux_byte = conv_first[7:0];
        endcase
    end
endmodule

// >>> core/expansion_port_output_control.sv
// expansion port output control register and output multiplexer
// assumes register writes arrive as a decoded subaddress strobe from the serial control bus
// assumes timing, lock and video inputs are synchronous to ref_clk
`timescale 1ns/100ps
`include "xport_ctl_defs.svh"

// What this block does
// - bit 6 clear: horizontal reference pin carries active-line reference
// - bit 6 set: horizontal reference pin carries the programmed sync pulse
// - bits 5:4 choose sync, field id, inverted sync or inverted field id
// - bit 3 clear: lock indicator is inverted horizontal lock status bit
// - bit 3 set: lock indicator is the fast lock signal
// - format 000 emits standard stream with timing reference codes
// - format 001 blanks fields by the programmed vertical window instead
// - format 010 emits plain 4:2:2 samples without timing codes
// - format 100 bypasses converter pair using sample bits 8:1
// - format 101 bypasses converter pair using sample bits 7:0
// - bypass: second converter on qualifier high, first on low
// - format 111 splits one sample: 8:1 on high, 7:0 on low
// - status pin shows the selected lock indicator when chosen
module expansion_port_output_control (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register access
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // timing inputs from the decoder core
    input wire logic horiz_ref,
    input wire logic horizontal_sync,
    input wire logic vertical_sync_pulse,
    input wire logic field_id,
    input wire logic vertical_window,
    input wire logic horiz_lock_status,
    input wire logic fast_lock,
    input wire logic clock_qualifier,
    input wire logic realtime_clock_in,
    // status pin source code
    input wire logic [3:0] status_source,
    // video and converter samples
    input wire logic [7:0] video_sample,
    input wire logic [8:0] conv_first,
    input wire logic [8:0] conv_second,
    // expansion port pins
    output logic xport_horiz_ref_pin,
    output logic xport_vert_ref_pin,
    output logic [7:0] expansion_data_bus,
    output logic realtime_clock_output,
    output logic realtime_clock_output_oe,
    output logic lock_indicator_output,
    output logic realtime_status_pin,
    output logic realtime_status_pin_oe
);
    // status pin source code that routes the lock indicator out
    localparam logic [3:0] STATUS_LOCK = `STATUS_SRC_LOCK;

    // control byte and its next value
    logic [7:0] ctl;
    logic [7:0] next_ctl;
    logic rt_clock_out_enable;
    logic xport_horiz_ref_select;
    logic [1:0] xport_vert_ref_select;
    logic lock_indicator_select;
    logic [2:0] port_format_select;

    // bypass byte from the sample multiplexer
    logic [7:0] mux_byte;

    // window-driven blanking for the modified stream
    logic blanking;

    // timing reference code sequencer state
    logic href_d;
    logic next_href_d;
    xport_ctl_pkg::trc_state_type trc;
    xport_ctl_pkg::trc_state_type next_trc;
    logic trc_eav;
    logic next_trc_eav;
    logic chroma_phase;
    logic next_chroma_phase;

    // next values of the registered pins
    logic [7:0] next_bus;
    logic next_hpin;
    logic next_vpin;
    logic next_lock;

    // one place decides whether an access targets the control register
    function automatic logic ctl_addressed(input logic [7:0] addr);
        ctl_addressed = (addr == `CTL_OFFSET);
    endfunction

    // register field split
    assign rt_clock_out_enable = ctl[`BIT_RTC_EN];
    assign xport_horiz_ref_select = ctl[`BIT_HREF_SEL];
    assign xport_vert_ref_select = ctl[`FLD_VREF_HI:`FLD_VREF_LO];
    assign lock_indicator_select = ctl[`BIT_LOCK_SEL];
    assign port_format_select = ctl[`FLD_FMT_HI:`FLD_FMT_LO];

    // control register write
    always_comb begin
        next_ctl = ctl;
        if (reg_write && ctl_addressed(reg_addr)) begin
            next_ctl = reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= `CTL_RESET;
        end else begin
            ctl <= next_ctl;
        end
    end

    // read back is combinational so the serial engine can sample in the same cycle
    // other subaddresses belong to neighbouring blocks and read back as zero here
    assign reg_hit = (reg_read || reg_write) && ctl_addressed(reg_addr);
    assign reg_rdata = (reg_read && ctl_addressed(reg_addr)) ? ctl : `OUT_RESET;


    // real-time clock pin: enable gates the driver
    // the clock itself passes straight through; only the pad driver is switched
    assign realtime_clock_output = realtime_clock_in;
    assign realtime_clock_output_oe = rt_clock_out_enable;

    // blanking differs between standard and window-driven formats
    always_comb begin
        if (port_format_select == 3'(xport_ctl_pkg::fmt_itu656_window)) begin
            blanking = !vertical_window;
        end else begin
            blanking = 1'b0;
        end
    end


    // timing reference code sequencer: starts on each edge of horiz_ref
    // an edge seen while a header is still running is dropped, so edges
    // closer than four cycles apart lose their header
    always_comb begin
        next_href_d = horiz_ref;
        next_trc = trc;
        next_trc_eav = trc_eav;
        next_chroma_phase = horiz_ref ? !chroma_phase : 1'b0;
        unique case (trc)
            xport_ctl_pkg::trc_idle: begin
                if (horiz_ref != href_d) begin
                    next_trc = xport_ctl_pkg::trc_lead;
                    next_trc_eav = href_d;
                end
            end
            xport_ctl_pkg::trc_lead: next_trc = xport_ctl_pkg::trc_zero;
            xport_ctl_pkg::trc_zero: next_trc = xport_ctl_pkg::trc_word;
            xport_ctl_pkg::trc_word: next_trc = xport_ctl_pkg::trc_idle;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            href_d <= 1'b0;
            trc <= xport_ctl_pkg::trc_idle;
            trc_eav <= 1'b0;
            chroma_phase <= 1'b0;
        end else begin
            href_d <= next_href_d;
            trc <= next_trc;
            trc_eav <= next_trc_eav;
            chroma_phase <= next_chroma_phase;
        end
    end


    // timing reference word: 1, field, blanking, eav, then protection bits
    // protection bits let the receiver correct one flipped bit of the word
    function automatic logic [7:0] trc_word(input logic f, input logic v, input logic h);
        trc_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    // bypass and split sample selection
    xport_sample_mux sample_mux (
        .format_code(port_format_select),
        .clock_qualifier(clock_qualifier),
        .conv_first(conv_first),
        .conv_second(conv_second),
        .mux_byte(mux_byte)
    );


    // data bus next value by format; reserved codes output blanking level
    // header words take priority over video so the receiver always finds them
    always_comb begin
        next_bus = `SAV_EAV_ZERO;
        unique case (xport_ctl_pkg::port_format_type'(port_format_select))
            xport_ctl_pkg::fmt_itu656, xport_ctl_pkg::fmt_itu656_window: begin
                unique case (trc)
                    xport_ctl_pkg::trc_lead: next_bus = `SAV_EAV_LEAD;
                    xport_ctl_pkg::trc_zero: next_bus = `SAV_EAV_ZERO;
                    xport_ctl_pkg::trc_word:
                        next_bus = trc_word(field_id, blanking, trc_eav);
                    xport_ctl_pkg::trc_idle: begin
                        if (blanking) begin
                            next_bus = chroma_phase ? `BLANK_LUMA : `BLANK_CHROMA;
                        end else begin
                            next_bus = video_sample;
                        end
                    end
                endcase
            end
            xport_ctl_pkg::fmt_plain422: next_bus = video_sample;
            xport_ctl_pkg::fmt_bypass_hi, xport_ctl_pkg::fmt_bypass_lo,
            xport_ctl_pkg::fmt_split: next_bus = mux_byte;
            // chroma blanking level for these codes; software keeps away from them
            xport_ctl_pkg::fmt_rsvd3, xport_ctl_pkg::fmt_rsvd6: next_bus = `BLANK_CHROMA;
        endcase
    end

    // reference pins and lock indicator next values
    always_comb begin
        // horizontal pin: active-line reference or programmed sync pulse
        if (xport_horiz_ref_select) begin
            next_hpin = horizontal_sync;
        end else begin
            next_hpin = horiz_ref;
        end

        // vertical pin: four sources, two of them inverted
        unique case (xport_ctl_pkg::vref_select_type'(xport_vert_ref_select))
            xport_ctl_pkg::vref_sync: begin
                next_vpin = vertical_sync_pulse;
            end
            xport_ctl_pkg::vref_field: begin
                next_vpin = field_id;
            end
            xport_ctl_pkg::vref_sync_inv: begin
                next_vpin = !vertical_sync_pulse;
            end
            xport_ctl_pkg::vref_field_inv: begin
                next_vpin = !field_id;
            end
        endcase

        // status bit is active-low locked, hence the inversion
        // the fast variant reacts sooner but chatters on unstable sources
        if (lock_indicator_select) begin
            next_lock = fast_lock;
        end else begin
            next_lock = !horiz_lock_status;
        end
    end


    // registered data outputs; the bus, both reference pins and the lock indicator move one cycle after their sources
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            expansion_data_bus <= `OUT_RESET;
            xport_horiz_ref_pin <= 1'b0;
            xport_vert_ref_pin <= 1'b0;
            lock_indicator_output <= 1'b0;
        end else begin
            expansion_data_bus <= next_bus;
            xport_horiz_ref_pin <= next_hpin;
            xport_vert_ref_pin <= next_vpin;
            lock_indicator_output <= next_lock;
        end
    end


    // status pin shows the lock indicator when its source code selects it
    // other source codes are served elsewhere, so the pad floats here
    assign realtime_status_pin = lock_indicator_output;
    assign realtime_status_pin_oe = (status_source == STATUS_LOCK);
endmodule

// >>> verif/xport_video_sink.sv
// capture controller model sitting on the expansion data bus
// assumes the bus is sampled on ref_clk, one word per cycle
`timescale 1ns/100ps
module xport_video_sink (
    // clock
    input wire logic ref_clk,
    // expansion port
    input wire logic [7:0] expansion_data_bus,
    // bus word from the previous sample, which is the timing code word whenever header_seen is set
    output logic [7:0] header_word,
    output logic header_seen
);
    logic [7:0] prev1;
    logic [7:0] prev2;
    // a header is FF, 00, then a code word with its top bit set
    always_ff @(posedge ref_clk) begin
        prev1 <= expansion_data_bus;
        prev2 <= prev1;
        header_word <= expansion_data_bus;
        header_seen <= prev2 == 8'hFF && prev1 == 8'h00 && expansion_data_bus[7];
    end
endmodule

// >>> verif/expansion_port_output_control_asserts.sv
// checker for the expansion port output control block
// assumes registered pins lag their inputs by one ref_clk cycle
`timescale 1ns/100ps
module xport_ctl_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register writes
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // timing, lock and samples
    input wire logic horiz_ref,
    input wire logic horizontal_sync,
    input wire logic vertical_sync_pulse,
    input wire logic field_id,
    input wire logic horiz_lock_status,
    input wire logic fast_lock,
    input wire logic clock_qualifier,
    input wire logic [8:0] conv_first,
    input wire logic [8:0] conv_second,
    // pins
    input wire logic xport_horiz_ref_pin,
    input wire logic xport_vert_ref_pin,
    input wire logic [7:0] expansion_data_bus,
    input wire logic realtime_clock_output_oe,
    input wire logic lock_indicator_output
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctl;
    logic vref_exp;
    logic [8:0] byp_src;
    logic [7:0] byp_exp;
    logic [7:0] split_exp;
    // shadow of the control byte, rebuilt from the write strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= 8'h00;
        end else if (reg_write && reg_addr == 8'h13) begin
            ctl <= reg_wdata;
        end
    end
    // expected pin and byte values from the shadow
    always_comb begin
        vref_exp = (ctl[4] ? field_id : vertical_sync_pulse) ^ ctl[5];
        byp_src = clock_qualifier ? conv_second : conv_first;
        byp_exp = ctl[0] ? byp_src[7:0] : byp_src[8:1];
        split_exp = clock_qualifier ? conv_first[8:1] : conv_first[7:0];
    end
    sequence s_trc;
        expansion_data_bus == 8'hFF ##1 expansion_data_bus == 8'h00 ##1 expansion_data_bus[7];
    endsequence
    property p_rtc; realtime_clock_output_oe == ctl[7]; endproperty
    property p_href; !ctl[6] |=> xport_horiz_ref_pin == $past(horiz_ref); endproperty
    property p_hs; ctl[6] |=> xport_horiz_ref_pin == $past(horizontal_sync); endproperty
    property p_vref; 1'b1 |=> xport_vert_ref_pin == $past(vref_exp); endproperty
    property p_lstd; !ctl[3] |=> lock_indicator_output == !$past(horiz_lock_status); endproperty
    property p_lfast; ctl[3] |=> lock_indicator_output == $past(fast_lock); endproperty
    property p_byp; ctl[2:1] == 2'b10 |=> expansion_data_bus == $past(byp_exp); endproperty
    property p_split; ctl[2:0] == 3'h7 |=> expansion_data_bus == $past(split_exp); endproperty
    property p_trc; ctl[2:1] == 2'b00 && $changed(horiz_ref) |-> ##[1:3] s_trc; endproperty
    a_rtc: assert property (p_rtc) else $error("clock output enable wrong");
    a_href: assert property (p_href) else $error("href pin wrong");
    a_hs: assert property (p_hs) else $error("sync pin wrong");
    a_vref: assert property (p_vref) else $error("vertical pin wrong");
    a_lstd: assert property (p_lstd) else $error("lock output wrong");
    a_lfast: assert property (p_lfast) else $error("fast lock output wrong");
    a_byp: assert property (p_byp) else $error("bypass byte wrong");
    a_split: assert property (p_split) else $error("split byte wrong");
    a_trc: assert property (p_trc) else $error("timing code missing");
endmodule
bind expansion_port_output_control xport_ctl_checker chk_u (.ref_clk, .rst_n, .reg_write,
    .reg_addr, .reg_wdata, .horiz_ref, .horizontal_sync, .vertical_sync_pulse, .field_id,
    .horiz_lock_status, .fast_lock, .clock_qualifier, .conv_first, .conv_second,
    .xport_horiz_ref_pin, .xport_vert_ref_pin, .expansion_data_bus,
    .realtime_clock_output_oe, .lock_indicator_output);

// >>> verif/test_expansion_port_output_control.sv
// self-checking bench for the expansion port output control block
// assumes the sink model and checker are compiled before this file
`timescale 1ns/100ps
module test_expansion_port_output_control;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, reg_hit;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, video_sample = 8'h3C;
    logic horiz_ref = 1'b0, horizontal_sync = 1'b0, vertical_sync_pulse = 1'b0;
    logic field_id = 1'b0, vertical_window = 1'b0, horiz_lock_status = 1'b0;
    logic fast_lock = 1'b0, clock_qualifier = 1'b0, realtime_clock_in = 1'b0;
    logic [3:0] status_source = 4'h4;
    logic [8:0] conv_first = 9'h1A5, conv_second = 9'h0C3;
    logic xport_horiz_ref_pin, xport_vert_ref_pin, realtime_clock_output, header_seen;
    logic realtime_clock_output_oe, lock_indicator_output, realtime_status_pin;
    logic realtime_status_pin_oe;
    logic [7:0] expansion_data_bus, header_word;
    int err_count = 0, tests_run = 0;
    expansion_port_output_control dut_u (.ref_clk, .rst_n, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_hit, .horiz_ref, .horizontal_sync, .vertical_sync_pulse,
        .field_id, .vertical_window, .horiz_lock_status, .fast_lock, .clock_qualifier,
        .realtime_clock_in, .status_source, .video_sample, .conv_first, .conv_second,
        .xport_horiz_ref_pin, .xport_vert_ref_pin, .expansion_data_bus, .realtime_clock_output,
        .realtime_clock_output_oe, .lock_indicator_output, .realtime_status_pin,
        .realtime_status_pin_oe);
    xport_video_sink sink_u (.ref_clk, .expansion_data_bus, .header_word, .header_seen);
    always #2 ref_clk = ~ref_clk;
    // each step ends 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_write = 1'b0;
        reg_addr = 8'h13;
    endtask
    task automatic t_regs();
        reg_read = 1'b1;
        reg_addr = 8'h13;
        #1 chk({reg_rdata[6:0], reg_hit}, 8'h01);
        wr(8'h12, 8'hFF);
        reg_addr = 8'h12;
        #1 chk({reg_rdata[6:0], reg_hit}, 8'h00);
        wr(8'h13, 8'h80);
        realtime_clock_in = 1'b1;
        #1 chk({reg_rdata[7:1], realtime_clock_output_oe}, 8'h81);
        chk({7'h00, realtime_clock_output}, 8'h01);
        wr(8'h13, 8'h00);
        chk({7'h00, realtime_clock_output_oe}, 8'h00);
    endtask
    task automatic t_pins();
        for (int k = 0; k < 8; k++) begin
            horiz_ref = k[1];
            horizontal_sync = !k[1];
            vertical_sync_pulse = k[0];
            field_id = !k[0];
            horiz_lock_status = k[2];
            fast_lock = k[2];
            video_sample = 8'h3C + 8'(k);
            wr(8'h13, {1'b0, k[0], k[2:1], k[0], 3'h2});
            step(1);
            chk({xport_horiz_ref_pin, xport_vert_ref_pin, lock_indicator_output, 5'h00},
                {k[0] ^ k[1], k[0] ^ k[1] ^ k[2], k[0] ~^ k[2], 5'h00});
            chk({realtime_status_pin, realtime_status_pin_oe, 6'h00},
                {k[0] ~^ k[2], 7'h40});
            chk(expansion_data_bus, video_sample);
        end
        status_source = 4'h0;
        #1 chk({7'h00, realtime_status_pin_oe}, 8'h00);
        status_source = 4'h4;
    endtask
    task automatic t_bypass();
        for (int q = 0; q < 2; q++) begin
            clock_qualifier = q[0];
            wr(8'h13, 8'h04);
            step(1);
            chk(expansion_data_bus, q[0] ? 8'h61 : 8'hD2);
            wr(8'h13, 8'h05);
            step(1);
            chk(expansion_data_bus, q[0] ? 8'hC3 : 8'hA5);
            wr(8'h13, 8'h07);
            step(1);
            chk(expansion_data_bus, q[0] ? 8'hD2 : 8'hA5);
        end
    endtask
    task automatic t_trc();
        logic found;
        logic [7:0] word;
        horiz_ref = 1'b0;
        wr(8'h13, 8'h00);
        step(4);
        for (int e = 0; e < 2; e++) begin
            horiz_ref = !horiz_ref;
            found = 1'b0;
            word = 8'h00;
            repeat (6) begin
                step(1);
                if (header_seen === 1'b1) begin
                    found = 1'b1;
                    word = header_word;
                end
            end
            chk({found, word[4], 6'h00}, {1'b1, !horiz_ref, 6'h00});
        end
        wr(8'h13, 8'h01);
        step(3);
        chk({7'h00, expansion_data_bus === 8'h80 || expansion_data_bus === 8'h10}, 8'h01);
        vertical_window = 1'b1;
        step(2);
        chk(expansion_data_bus, video_sample);
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // reset for ten cycles, then the scenarios in turn
    initial begin
        step(10);
        rst_n = 1'b1;
        step(1);
        t_regs();
        t_pins();
        t_bypass();
        t_trc();
        tally_and_finish();
    end
    // watchdog well past the 65 or so cycles the scenarios need
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule
